// File: core/smp_parser.sv
// SCPI program message parser that turns a character stream into tokens.
`timescale 1ns/1ps
module smp_parser (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Character stream from the bus link
  input wire logic char_valid_in,
  input wire logic [7:0] char_in,
  input wire logic eoi_in,
  output logic char_ready_out,
  // Secondary address node selection
  input wire logic sec_addr_en_in,
  input wire logic sec_addr_valid_in,
  input wire logic [4:0] sec_addr_in,
  // Token stream to the command executor
  output logic tok_valid_out,
  input wire logic tok_ready_in,
  output logic [2:0] tok_kind_out,
  output logic [7:0] tok_code_out,
  output logic [1:0] tok_level_out,
  output logic tok_query_out,
  output logic [4:0] tok_node_out,
  // Status
  output logic [4:0] node_out,
  output logic syntax_err_out
);
  typedef enum logic [2:0] {
    ST_START = 3'h0,
    ST_KW = 3'h1,
    ST_NODE = 3'h2,
    ST_QUERY = 3'h3,
    ST_DATA = 3'h4,
    ST_COMMON = 3'h5,
    ST_DISCARD = 3'h6
  } smp_state_t;

  typedef struct packed {
    smp_state_t st;
    logic [smp_pkg::KW_MAX*8-1:0] text;
    logic [3:0] len;
    logic [1:0] lvl;
    logic [1:0] base;
    logic [3:0][4:0] path;
    logic [5:0] suffix;
    logic has_suffix;
    logic [4:0] node;
    logic inst_sel;
    logic [5:0] data_val;
    logic data_num;
    logic data_bad;
    logic cr_seen;
    logic eoi_pend;
    logic pend;
    smp_pkg::smp_tok_kind_t pend_kind;
    logic ready;
    logic err;
  } smp_core_st_t;

  smp_core_st_t s_reg;
  smp_core_st_t s_next;
  smp_pkg::smp_tok_t tok;
  smp_pkg::smp_tok_t head;
  smp_pkg::smp_tok_kind_t ek;
  smp_pkg::smp_tok_kind_t end_kind;
  logic [7:0] c;
  logic [7:0] cu;
  logic [7:0] ecode;
  logic eq;
  logic synth;
  logic take;
  logic term;
  logic emit;
  logic bad;
  logic unit_end;
  logic msg_end;
  logic delim_ok;
  logic pop;
  logic bin_ready;
  logic [1:0] bcnt;
  logic [2:0] cnt_n;
  logic [1:0] plvl;
  logic mt_hit;
  logic [4:0] mt_id;

  function automatic logic is_alpha(input logic [7:0] ch);
    return ((ch >= smp_pkg::CH_UA) && (ch <= smp_pkg::CH_UZ)) ||
      ((ch >= smp_pkg::CH_LA) && (ch <= smp_pkg::CH_LZ));
  endfunction

  function automatic logic is_digit(input logic [7:0] ch);
    return (ch >= smp_pkg::CH_D0) && (ch <= smp_pkg::CH_D9);
  endfunction

  function automatic logic node_ok(input logic [5:0] v);
    return (v >= {1'b0, smp_pkg::NODE_MIN}) && (v <= {1'b0, smp_pkg::NODE_MAX});
  endfunction

  // Saturates at 63 so that long digit strings stay out of the valid node range.
  function automatic logic [5:0] dec_acc(input logic [5:0] acc, input logic [7:0] ch);
    logic [9:0] t;
    t = 10'(acc) * 10'h00a + 10'(ch - smp_pkg::CH_D0);
    return (t > 10'h03f) ? 6'h3f : t[5:0];
  endfunction

  assign plvl = s_reg.lvl - 2'h1;

  smp_kw_match u_match (
    .text_in(s_reg.text),
    .len_in(s_reg.len),
    .at_root_in(s_reg.lvl == 2'h0),
    .parent_in(s_reg.path[plvl]),
    .hit_out(mt_hit),
    .id_out(mt_id)
  );

  always_comb begin
    s_next = s_reg;
    s_next.err = 1'b0;
    emit = 1'b0;
    ek = smp_pkg::TK_DATA;
    eq = 1'b0;
    bad = 1'b0;
    unit_end = 1'b0;
    msg_end = 1'b0;
    pop = tok_valid_out && tok_ready_in;
    // An END on a non-terminator byte is replayed as a line feed once no end token is pending and the buffer has room.
    synth = s_reg.eoi_pend && !s_reg.pend && bin_ready;
    take = synth || (char_valid_in && s_reg.ready);
    c = synth ? smp_pkg::CH_LF : char_in;
    cu = ((c >= smp_pkg::CH_LA) && (c <= smp_pkg::CH_LZ)) ? c - smp_pkg::CASE_OFS : c;
    ecode = c;
    term = (c == smp_pkg::CH_LF) || (c == smp_pkg::CH_CR);
    delim_ok = term || (c == smp_pkg::CH_QUERY) || (c == smp_pkg::CH_SPACE) ||
      (c == smp_pkg::CH_SEMI) || ((c == smp_pkg::CH_COLON) && (s_reg.lvl != smp_pkg::LVL_TOP));
    if (sec_addr_en_in && sec_addr_valid_in && node_ok({1'b0, sec_addr_in})) begin
      s_next.node = sec_addr_in;
    end
    if (s_reg.pend) begin
      if (bin_ready) begin
        emit = 1'b1;
        ek = s_reg.pend_kind;
        s_next.pend = 1'b0;
      end
    end else if (take) begin
      s_next.cr_seen = !synth && (c == smp_pkg::CH_CR);
      if (synth) begin
        s_next.eoi_pend = 1'b0;
      end else if (eoi_in && !term) begin
        s_next.eoi_pend = 1'b1;
      end
      // The line feed of a CR LF pair is swallowed so it ends nothing twice.
      if (!((c == smp_pkg::CH_LF) && s_reg.cr_seen)) begin
        case (s_reg.st)
          ST_START: begin
            if (c == smp_pkg::CH_SPACE) begin
            end else if (term) begin
              msg_end = 1'b1;
            end else if (c == smp_pkg::CH_COLON) begin
              s_next.lvl = 2'h0;
              s_next.st = ST_KW;
            end else if (is_alpha(c)) begin
              s_next.lvl = s_reg.base;
              s_next.st = ST_KW;
              s_next.text[{s_reg.len, 3'h0} +: 8] = cu;
              s_next.len = s_reg.len + 4'h1;
            end else if (c == smp_pkg::CH_STAR) begin
              s_next.st = ST_COMMON;
              emit = 1'b1;
              ek = smp_pkg::TK_COMMON;
            end else begin
              bad = 1'b1;
            end
          end
          ST_KW, ST_NODE: begin
            if (is_alpha(c) && (s_reg.st == ST_KW)) begin
              if (s_reg.len == smp_pkg::KW_MAX_LEN) begin
                bad = 1'b1;
              end else begin
                s_next.text[{s_reg.len, 3'h0} +: 8] = cu;
                s_next.len = s_reg.len + 4'h1;
              end
            end else if (is_digit(c) && (s_reg.len != 4'h0)) begin
              s_next.st = ST_NODE;
              s_next.suffix = dec_acc(s_reg.suffix, c);
              s_next.has_suffix = 1'b1;
            end else if ((s_reg.len == 4'h0) || !mt_hit || !delim_ok ||
                (s_reg.has_suffix && !node_ok(s_reg.suffix))) begin
              bad = 1'b1;
            end else begin
              emit = 1'b1;
              ek = smp_pkg::TK_KEYWORD;
              ecode = {3'h0, mt_id};
              eq = c == smp_pkg::CH_QUERY;
              s_next.path[s_reg.lvl] = mt_id;
              if (s_reg.has_suffix) begin
                s_next.node = s_reg.suffix[4:0];
              end
              s_next.inst_sel = (s_reg.lvl == 2'h1) && (s_reg.path[0] == smp_pkg::KW_INST) &&
                (mt_id == smp_pkg::KW_SEL);
              s_next.text = '0;
              s_next.len = 4'h0;
              s_next.suffix = 6'h00;
              s_next.has_suffix = 1'b0;
              if (c == smp_pkg::CH_COLON) begin
                s_next.lvl = s_reg.lvl + 2'h1;
                s_next.st = ST_KW;
              end else if (c == smp_pkg::CH_QUERY) begin
                s_next.st = ST_QUERY;
              end else if (c == smp_pkg::CH_SPACE) begin
                s_next.st = ST_DATA;
                s_next.data_val = 6'h00;
                s_next.data_num = 1'b0;
                s_next.data_bad = 1'b0;
              end else if (c == smp_pkg::CH_SEMI) begin
                unit_end = 1'b1;
              end else begin
                msg_end = 1'b1;
              end
            end
          end
          ST_QUERY: begin
            if (c == smp_pkg::CH_SPACE) begin
              s_next.st = ST_DATA;
              s_next.data_val = 6'h00;
              s_next.data_num = 1'b0;
              s_next.data_bad = 1'b0;
            end else if (c == smp_pkg::CH_SEMI) begin
              unit_end = 1'b1;
            end else if (term) begin
              msg_end = 1'b1;
            end else begin
              bad = 1'b1;
            end
          end
          ST_DATA: begin
            if (c == smp_pkg::CH_SEMI) begin
              unit_end = 1'b1;
            end else if (term) begin
              msg_end = 1'b1;
            end else begin
              emit = 1'b1;
              ek = smp_pkg::TK_DATA;
              if (is_digit(c)) begin
                s_next.data_val = dec_acc(s_reg.data_val, c);
                s_next.data_num = !s_reg.data_bad;
              end else if (c != smp_pkg::CH_SPACE) begin
                s_next.data_num = 1'b0;
                s_next.data_bad = 1'b1;
              end
            end
          end
          ST_COMMON: begin
            if (c == smp_pkg::CH_SEMI) begin
              unit_end = 1'b1;
            end else if (term) begin
              msg_end = 1'b1;
            end else begin
              emit = 1'b1;
              ek = smp_pkg::TK_COMMON;
            end
          end
          ST_DISCARD: begin
            if (term) begin
              msg_end = 1'b1;
            end
          end
          default: begin
            s_next.st = ST_START;
          end
        endcase
      end
    end
    if (bad) begin
      emit = 1'b1;
      ek = smp_pkg::TK_ERROR;
      s_next.err = 1'b1;
      s_next.text = '0;
      s_next.len = 4'h0;
      s_next.suffix = 6'h00;
      s_next.has_suffix = 1'b0;
      s_next.st = ST_DISCARD;
      msg_end = term;
    end
    end_kind = msg_end ? smp_pkg::TK_MSG_END : smp_pkg::TK_UNIT_END;
    if (unit_end || msg_end) begin
      if ((s_reg.st == ST_DATA) && s_reg.inst_sel && s_reg.data_num &&
          node_ok(s_reg.data_val)) begin
        s_next.node = s_reg.data_val[4:0];
      end
      if (emit) begin
        s_next.pend = 1'b1;
        s_next.pend_kind = end_kind;
      end else begin
        emit = 1'b1;
        ek = end_kind;
      end
      s_next.st = ST_START;
      if (msg_end) begin
        s_next.lvl = 2'h0;
        s_next.base = 2'h0;
      end else if (s_reg.st != ST_COMMON) begin
        s_next.base = s_reg.lvl;
      end
    end
    tok.kind = ek;
    tok.code = ecode;
    tok.level = s_reg.lvl;
    tok.query = eq;
    tok.node = s_next.node;
    // Ready is a flop, so it is set only when the slot it promises is already free.
    cnt_n = {1'b0, bcnt} + {2'h0, emit} - {2'h0, pop};
    s_next.ready = !s_next.pend && !s_next.eoi_pend && (cnt_n < 3'h2);
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
      s_reg.node <= smp_pkg::NODE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  smp_tok_buf #(
    .W($bits(smp_pkg::smp_tok_t))
  ) u_buf (
    .clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(emit),
    .in_ready_out(bin_ready),
    .in_data_in(tok),
    .out_valid_out(tok_valid_out),
    .out_ready_in(tok_ready_in),
    .out_data_out(head),
    .count_out(bcnt)
  );

  assign tok_kind_out = head.kind;
  assign tok_code_out = head.code;
  assign tok_level_out = head.level;
  assign tok_query_out = head.query;
  assign tok_node_out = head.node;
  assign char_ready_out = s_reg.ready;
  assign node_out = s_reg.node;
  assign syntax_err_out = s_reg.err;
endmodule // smp_parser

// File: core/smp_pkg.sv
// Shared constants, keyword table and token layout of the SCPI message parser.
package smp_pkg;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_D0 = 8'h30;
  localparam logic [7:0] CH_D9 = 8'h39;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UZ = 8'h5a;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7a;
  localparam logic [7:0] CASE_OFS = 8'h20;
  localparam int KW_MAX = 12;
  localparam int KW_N = 28;
  localparam logic [3:0] KW_MAX_LEN = 4'hc;
  localparam logic [1:0] LVL_TOP = 2'h3;
  localparam logic [4:0] NODE_MIN = 5'h01;
  localparam logic [4:0] NODE_MAX = 5'h1f;
  localparam logic [4:0] NODE_RESET = 5'h01;
  localparam logic [4:0] KW_STAT = 5'h04;
  localparam logic [4:0] KW_INST = 5'h06;
  localparam logic [4:0] KW_SEL = 5'h14;
  localparam logic [4:0] PARENT_ANY = 5'h1f;
  // Keyword codes are the table index; ids 0 to 9 may open a command at root.
  localparam logic [95:0] KW_TEXT [KW_N] = '{
    "INITIATE", "MEASURE", "OUTPUT", "SOURCE", "STATUS", "SYSTEM", "INSTRUMENT",
    "VOLTAGE", "CURRENT", "FUNCTION", "OPERATION", "PRESET", "QUESTIONABLE",
    "CONDITION", "ENABLE", "EVENT", "LEVEL", "IMMEDIATE", "TRIGGERED", "MODE",
    "SELECT", "CONTINUOUS", "ERROR", "STATE", "CODE", "ALL", "VERSION",
    "COMMUNICATE"};
  localparam logic [KW_N-1:0] KW_ROOT_OK = 28'h00003ff;
  localparam logic [4:0] KW_PARENT [KW_N] = '{
    PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY,
    PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY, KW_STAT, KW_STAT, KW_STAT,
    PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY,
    PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY, PARENT_ANY,
    PARENT_ANY, PARENT_ANY, PARENT_ANY};

  typedef enum logic [2:0] {
    TK_KEYWORD = 3'h0,
    TK_DATA = 3'h1,
    TK_UNIT_END = 3'h2,
    TK_MSG_END = 3'h3,
    TK_ERROR = 3'h4,
    TK_COMMON = 3'h5
  } smp_tok_kind_t;

  typedef struct packed {
    smp_tok_kind_t kind;
    logic [7:0] code;
    logic [1:0] level;
    logic query;
    logic [4:0] node;
  } smp_tok_t;

  function automatic logic [3:0] kw_len(input int id);
    logic [3:0] l;
    l = 4'h0;
    for (int i = 0; i < KW_MAX; i++) begin
      if (KW_TEXT[id][i*8 +: 8] != 8'h00) begin
        l = 4'(i + 1);
      end
    end
    return l;
  endfunction

  function automatic logic [7:0] kw_char(input int id, input int i);
    int l;
    l = int'(kw_len(id));
    return (i < l) ? KW_TEXT[id][(l-1-i)*8 +: 8] : 8'h00;
  endfunction

  function automatic logic [3:0] kw_short_len(input logic [3:0] l, input logic [7:0] c4);
    logic vowel;
    vowel = (c4 == "A") || (c4 == "E") || (c4 == "I") || (c4 == "O") || (c4 == "U");
    if (l <= 4'h4) begin
      return l;
    end
    return vowel ? 4'h3 : 4'h4;
  endfunction
endpackage

// File: core/smp_tok_buf.sv
// Two-entry token buffer whose head entry drives the output directly.
`timescale 1ns/1ps
module smp_tok_buf #(
  parameter int W = $bits(smp_pkg::smp_tok_t)
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out,
  output logic [1:0] count_out
);
  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] cnt;
    logic vld;
  } smp_buf_st_t;
  smp_buf_st_t s_reg;
  smp_buf_st_t s_next;
  logic push;
  logic pop;

  always_comb begin
    s_next = s_reg;
    pop = s_reg.vld && out_ready_in;
    push = in_valid_in && (s_reg.cnt != 2'h2);
    case ({push, pop})
      2'b10: begin
        if (s_reg.cnt == 2'h0) begin
          s_next.head = in_data_in;
        end else begin
          s_next.tail = in_data_in;
        end
        s_next.cnt = s_reg.cnt + 2'h1;
      end
      2'b01: begin
        s_next.head = s_reg.tail;
        s_next.cnt = s_reg.cnt - 2'h1;
      end
      2'b11: begin
        if (s_reg.cnt == 2'h1) begin
          s_next.head = in_data_in;
        end else begin
          s_next.head = s_reg.tail;
          s_next.tail = in_data_in;
        end
      end
      default: begin
      end
    endcase
    s_next.vld = s_next.cnt != 2'h0;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready_out = s_reg.cnt != 2'h2;
  assign out_valid_out = s_reg.vld;
  assign out_data_out = s_reg.head;
  assign count_out = s_reg.cnt;
endmodule // smp_tok_buf

// File: core/smp_kw_match.sv
// Keyword table matcher: exact short or long form, checked against tree position.
`timescale 1ns/1ps
module smp_kw_match (
  // Collected keyword, upper case, first letter in the low byte
  input wire logic [smp_pkg::KW_MAX*8-1:0] text_in,
  input wire logic [3:0] len_in,
  // Tree position
  input wire logic at_root_in,
  input wire logic [4:0] parent_in,
  // Result
  output logic hit_out,
  output logic [4:0] id_out
);
  logic [smp_pkg::KW_N-1:0] ok;

  for (genvar g = 0; g < smp_pkg::KW_N; g++) begin : g_kw
    logic same;
    logic [3:0] ll;
    always_comb begin
      ll = smp_pkg::kw_len(g);
      same = 1'b1;
      for (int i = 0; i < smp_pkg::KW_MAX; i++) begin
        if ((4'(i) < len_in) && (text_in[i*8 +: 8] != smp_pkg::kw_char(g, i))) begin
          same = 1'b0;
        end
      end
    end
    // Truncations other than the two exact lengths never match.
    assign ok[g] = same && ((len_in == ll) ||
      (len_in == smp_pkg::kw_short_len(ll, smp_pkg::kw_char(g, 3)))) &&
      (at_root_in ? smp_pkg::KW_ROOT_OK[g] :
      ((smp_pkg::KW_PARENT[g] == smp_pkg::PARENT_ANY) ||
      (smp_pkg::KW_PARENT[g] == parent_in)));
  end

  // STATE and STATUS share a short form, so the tree position picks the entry.
  // Only STATUS may open a command at root; below the root the higher id, STATE, wins.
  always_comb begin
    hit_out = 1'b0;
    id_out = 5'h00;
    for (int k = 0; k < smp_pkg::KW_N; k++) begin
      if (ok[k]) begin
        hit_out = 1'b1;
        id_out = 5'(k);
      end
    end
  end
endmodule // smp_kw_match

// File: sim/smp_parser_sva.sv
// Concurrent checks on the parser ports.
`timescale 1ns/1ps
module smp_parser_sva (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Character side
  input wire logic char_valid_in,
  input wire logic [7:0] char_in,
  input wire logic char_ready_out,
  // Node selection
  input wire logic sec_addr_en_in,
  input wire logic sec_addr_valid_in,
  input wire logic [4:0] sec_addr_in,
  // Token side
  input wire logic tok_valid_out,
  input wire logic tok_ready_in,
  input wire logic [2:0] tok_kind_out,
  input wire logic [7:0] tok_code_out,
  input wire logic [1:0] tok_level_out,
  input wire logic [4:0] tok_node_out,
  input wire logic [4:0] node_out,
  input wire logic syntax_err_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic after_end_reg;
  logic sel_ok;
  assign sel_ok = sec_addr_en_in && sec_addr_valid_in && sec_addr_in != 5'h00;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      after_end_reg <= 1'b1;
    end else if (tok_valid_out && tok_ready_in && tok_kind_out == 3'h3) begin
      after_end_reg <= 1'b1;
    end else if (tok_valid_out && tok_ready_in && tok_kind_out == 3'h0) begin
      after_end_reg <= 1'b0;
    end
  end
  property p_node_reset; $rose(resetn_in) |-> node_out == 5'h01; endproperty
  a_node_reset: assert property (p_node_reset) else $error("node not 1 after reset");
  property p_tok_hold;
    tok_valid_out && !tok_ready_in |=> tok_valid_out && $stable(tok_kind_out)
      && $stable(tok_code_out) && $stable(tok_level_out) && $stable(tok_node_out);
  endproperty
  a_tok_hold: assert property (p_tok_hold) else $error("token changed before taken");
  property p_sec_sel;
    sel_ok && !char_valid_in && char_ready_out |=> node_out == $past(sec_addr_in);
  endproperty
  a_sec_sel: assert property (p_sec_sel) else $error("secondary address ignored");
  property p_node_hold;
    !sel_ok && !char_valid_in && char_ready_out |=> $stable(node_out);
  endproperty
  a_node_hold: assert property (p_node_hold) else $error("node changed unprompted");
  property p_err_pulse; syntax_err_out |=> !syntax_err_out; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error flag held");
  property p_err_tok;
    syntax_err_out |-> ##[0:100] (tok_valid_out && tok_kind_out == 3'h4);
  endproperty
  a_err_tok: assert property (p_err_tok) else $error("no error token");
  property p_root_after_end;
    tok_valid_out && tok_kind_out == 3'h0 && after_end_reg |-> tok_level_out == 2'h0;
  endproperty
  a_root_after_end: assert property (p_root_after_end) else $error("not at root");
  property p_cr_end;
    char_valid_in && char_ready_out && char_in == 8'h0d
      |-> ##[1:100] (tok_valid_out && tok_kind_out == 3'h3);
  endproperty
  a_cr_end: assert property (p_cr_end) else $error("no message end after CR");
endmodule // smp_parser_sva
bind smp_parser smp_parser_sva u_sva (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .char_valid_in(char_valid_in), .char_in(char_in), .char_ready_out(char_ready_out),
  .sec_addr_en_in(sec_addr_en_in), .sec_addr_valid_in(sec_addr_valid_in),
  .sec_addr_in(sec_addr_in), .tok_valid_out(tok_valid_out), .tok_ready_in(tok_ready_in),
  .tok_kind_out(tok_kind_out), .tok_code_out(tok_code_out), .tok_level_out(tok_level_out),
  .tok_node_out(tok_node_out), .node_out(node_out), .syntax_err_out(syntax_err_out));

// File: sim/smp_host_model.sv
// Bus controller model that sends program messages byte by byte.
`timescale 1ns/1ps
module smp_host_model (
  // Clock
  input wire logic clk_in,
  // Byte handshake
  input wire logic ready_in,
  output logic valid_out,
  output logic [7:0] char_out,
  output logic eoi_out
);
  initial begin
    valid_out = 1'b0;
    char_out = 8'h00;
    eoi_out = 1'b0;
  end
  // Every letter of the chosen form is sent; the caller supplies the terminator.
  task automatic send(input string s, input bit end_flag);
    for (int i = 0; i < s.len(); i++) begin
      valid_out = 1'b1;
      char_out = s[i];
      eoi_out = end_flag && (i == s.len() - 1);
      do @(posedge clk_in); while (ready_in !== 1'b1);
      #1;
    end
    valid_out = 1'b0;
    eoi_out = 1'b0;
    // A released line must not keep showing the last byte.
    char_out = ~char_out;
  endtask
endmodule // smp_host_model

// File: sim/tb.sv
// Self-checking bench for the message parser.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic resetn_in, tok_ready_in, sec_addr_en_in, sec_addr_valid_in;
  logic [4:0] sec_addr_in;
  logic char_valid_in, eoi_in, char_ready_out, tok_valid_out, tok_query_out, syntax_err_out;
  logic [7:0] char_in, tok_code_out;
  logic [2:0] tok_kind_out;
  logic [1:0] tok_level_out;
  logic [4:0] tok_node_out, node_out;
  logic [18:0] toks[$];
  int num_errors = 0, tests_run = 0, cyc = 0, err_cnt = 0;
  bit stall = 0;
  smp_parser u_smp_parser (.core_clk_in(core_clk), .resetn_in(resetn_in),
    .char_valid_in(char_valid_in), .char_in(char_in), .eoi_in(eoi_in),
    .char_ready_out(char_ready_out), .sec_addr_en_in(sec_addr_en_in),
    .sec_addr_valid_in(sec_addr_valid_in), .sec_addr_in(sec_addr_in),
    .tok_valid_out(tok_valid_out), .tok_ready_in(tok_ready_in), .tok_kind_out(tok_kind_out),
    .tok_code_out(tok_code_out), .tok_level_out(tok_level_out), .tok_query_out(tok_query_out),
    .tok_node_out(tok_node_out), .node_out(node_out), .syntax_err_out(syntax_err_out));
  smp_host_model u_smp_host_model (.clk_in(core_clk), .ready_in(char_ready_out),
    .valid_out(char_valid_in), .char_out(char_in), .eoi_out(eoi_in));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (tok_valid_out === 1'b1 && tok_ready_in === 1'b1)
      toks.push_back({tok_kind_out, tok_code_out, tok_level_out, tok_query_out, tok_node_out});
    if (syntax_err_out === 1'b1) err_cnt++;
    #1 tok_ready_in = stall ? (cyc[1:0] == 2'h0) : 1'b1;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input string s, input bit end_flag = 1'b0);
    int n;
    n = 0;
    toks.delete();
    u_smp_host_model.send(s, end_flag);
    while ((toks.size() == 0 || toks[$][18:16] !== 3'h3) && n < 300) begin
      @(posedge core_clk);
      #1 n++;
    end
    check("message end", toks.size() != 0 && toks[$][18:16] === 3'h3, 1'b1);
  endtask
  task automatic kw(input int i, input logic [7:0] code, input logic [1:0] lv, input logic q);
    logic [18:0] t;
    t = toks[i];
    check("kw kind", t[18:16], 3'h0);
    check("kw code", t[15:8], code);
    check("kw level", t[7:6], lv);
    check("kw query", t[5], q);
  endtask
  task automatic t_forms;
    string m[8] = '{"INIT\n", "meas?\n", "OuTpUt\n", "sour\n", "STATUS?\n", "syst\n",
      "VOLTAGE\n", "Curr\n"};
    logic [7:0] c[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08};
    for (int i = 0; i < 8; i++) begin
      run(m[i]);
      kw(0, c[i], 2'h0, i == 1 || i == 4);
    end
    run("syst:error?\n");
    kw(1, 8'h16, 2'h1, 1'b1);
    run("SOUR:VOLT:LEV\n");
    kw(2, 8'h10, 2'h2, 1'b0);
    run("OUTP:STAT\n");
    kw(1, 8'h17, 2'h1, 1'b0);
  endtask
  task automatic t_bad;
    string m[5] = '{"OUTPU\n", "INIT:IMME\n", "VOL\n", "STAT:ENABL\n", "VOLTX 5;CURR\n"};
    int e;
    foreach (m[i]) begin
      e = err_cnt;
      run(m[i]);
      check("error token", toks[toks.size() - 2][18:16], 3'h4);
      check("error pulses", err_cnt - e, 1);
    end
    check("discarded", toks.size(), 2);
    run("CURR\n");
    kw(0, 8'h08, 2'h0, 1'b0);
  endtask
  task automatic t_tree;
    for (int s = 0; s < 2; s++) begin
      stall = (s == 1);
      run("STAT:OPER:COND?;ENAB 16\n");
      kw(2, 8'h0d, 2'h2, 1'b1);
      check("unit end", toks[3][18:16], 3'h2);
      kw(4, 8'h0e, 2'h2, 1'b0);
      check("data", {toks[5][18:16], toks[5][15:8]}, {3'h1, 8'h31});
      check("count", toks.size(), 8);
    end
    stall = 0;
    run("MEAS:VOLT?;:CURR?\n");
    kw(3, 8'h08, 2'h0, 1'b1);
    run("MEAS:VOLT?;CURR?\n");
    kw(3, 8'h08, 2'h1, 1'b1);
    run("MEAS:VOLT?;*RST;CURR?\n");
    check("common", {toks[4][18:16], toks[4][15:8]}, {3'h5, 8'h52});
    kw(8, 8'h08, 2'h1, 1'b1);
  endtask
  task automatic t_term;
    string m[4] = '{"STAT:PRES\n", "STAT:PRES\r", "STAT:PRES\r\n", "STAT:PRES"};
    foreach (m[i]) begin
      run(m[i], i == 3);
      kw(1, 8'h0b, 2'h1, 1'b0);
      check("terminated", toks.size(), 3);
    end
    run("OPER\n");
    check("root after end", toks[0][18:16], 3'h4);
  endtask
  task automatic sec(input logic en, input logic [4:0] v, input logic [4:0] exp);
    sec_addr_en_in = en;
    sec_addr_valid_in = 1'b1;
    sec_addr_in = v;
    @(posedge core_clk);
    #1 sec_addr_valid_in = 1'b0;
    @(posedge core_clk);
    #1 check("node sec", node_out, exp);
  endtask
  task automatic t_node;
    check("node reset", node_out, 5'h01);
    run("meas2:volt?\n");
    check("suffix", toks[1][4:0], 5'h02);
    run("VOLT\n");
    check("sticky", toks[0][4:0], 5'h02);
    run("VOLT32\n");
    check("range", {toks[0][18:16], node_out}, {3'h4, 5'h02});
    run("VOLT31\n");
    check("top node", node_out, 5'h1f);
    run("INST:SEL 10\n");
    check("select", node_out, 5'h0a);
    sec(1'b1, 5'h05, 5'h05);
    sec(1'b0, 5'h07, 5'h05);
    sec(1'b1, 5'h00, 5'h05);
  endtask
  initial begin
    resetn_in = 1'b0;
    tok_ready_in = 1'b1;
    sec_addr_en_in = 1'b0;
    sec_addr_valid_in = 1'b0;
    sec_addr_in = 5'h00;
    repeat (8) @(posedge core_clk);
    #1 resetn_in = 1'b1;
    @(posedge core_clk);
    #1 t_node();
    t_forms();
    t_bad();
    t_tree();
    t_term();
    close_out();
  end
endmodule // tb
